// ===== src/obd_pkg.sv
// Package with opcodes, cycle counts and carrier types for the OR and block output executor.
package obd_pkg;
   // Opcode patterns in the top bits of the first instruction word; block output subcode in bits 3:1.
   localparam logic [6:0] OR_REG_OP = 7'h42;
   localparam logic [6:0] OR_IND_OP = 7'h02;
   localparam logic [6:0] OR_MEM_OP = 7'h22;
   localparam logic [7:0] OR_IMM_WORD_OP = 8'h05;
   localparam logic [7:0] OR_IMM_BYTE_OP = 8'h04;
   localparam logic [6:0] BLK_OUT_OP = 7'h1d;
   localparam logic [2:0] BLK_OUT_DEC_SUB = 3'h5;
   // Field positions.
   localparam int SIZE_BIT = 8;
   localparam int SPECIAL_BIT = 0;
   // Cycle counts per form.
   localparam logic [4:0] CYC_OR_REG = 5'h04;
   localparam logic [4:0] CYC_OR_IMM = 5'h07;
   localparam logic [4:0] CYC_OR_IND = 5'h07;
   localparam logic [4:0] CYC_OR_DA_NS = 5'h09;
   localparam logic [4:0] CYC_OR_DA_SS = 5'h0a;
   localparam logic [4:0] CYC_OR_DA_SL = 5'h0c;
   localparam logic [4:0] CYC_OR_X_NS = 5'h0a;
   localparam logic [4:0] CYC_OR_X_SS = 5'h0a;
   localparam logic [4:0] CYC_OR_X_SL = 5'h0d;
   localparam logic [4:0] CYC_BLK_SETUP = 5'h0b;
   localparam logic [4:0] CYC_BLK_ELEM = 5'h0a;
   localparam logic [4:0] CYC_INT_EXTRA = 5'h07;
   // Reset values.
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // Word sent to the I/O side.
   typedef struct packed {
      logic [15:0] port;
      logic [15:0] data;
      logic word;
      logic special;
   } obd_io_type;
   // Flags produced by an OR.
   typedef struct packed {
      logic zero;
      logic sign;
      logic parity;
   } obd_flag_type;
endpackage

// ===== src/obd_buf.sv
// Two-entry buffer with valid and ready on both sides.
module obd_buf #(
   parameter int WIDTH = 34
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [2];
   logic [WIDTH-1:0] next_mem [2];
   logic [1:0] count, next_count;
   logic rd, next_rd;
   logic wr, next_wr;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd];

   // Next pointer and storage values.
   always_comb begin
      logic push;
      logic pop;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_mem = mem;
      next_rd = rd;
      next_wr = wr;
      next_count = count;
      if (push) begin
         next_mem[wr] = in_data;
         next_wr = ~wr;
      end
      if (pop) begin
         next_rd = ~rd;
      end
      if (push && !pop) begin
         next_count = count + 2'h1;
      end else if (pop && !push) begin
         next_count = count - 2'h1;
      end
   end

   // Registers the buffer state.
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 2'h0;
         rd <= 1'b0;
         wr <= 1'b0;
      end else begin
         count <= next_count;
         rd <= next_rd;
         wr <= next_wr;
      end
      mem <= next_mem;
   end
endmodule // obd_buf

// ===== src/obd_exec.sv
// Executor for the OR instruction family and the decrementing block output instruction.
// Operation
// - OR writes destination OR source into destination; source stays.
// - Zero and sign from result; byte form sets parity flag.
// - Register OR decoded from its pattern, four cycles.
// - Immediate OR word and byte patterns with data word, seven cycles.
// - Indirect OR needs nonzero source field, seven cycles.
// - Direct OR nine, ten short segmented, twelve long segmented cycles.
// - Indexed OR needs nonzero index; ten, ten, thirteen cycles.
// - Pointer field is word register, or pair when segmented.
// - Each step reads memory at source pointer, writes to port.
// - Plain variants use standard I/O, special variants special I/O.
// - Port address is sixteen bits from destination register.
// - Source pointer drops by one for bytes, two for words.
// - Counter register decrements by one after each transfer.
// - Port register stays unchanged through the instruction.
// - Repeat until decremented counter reaches zero, then finish.
// - Interrupts accepted between any two transfer steps.
// - Instruction start address saved so the instruction resumes.
// - Each accepted interrupt adds seven cycles.
// - Two-word block output format; one bit selects special I/O.
// - Block output takes eleven plus ten cycles per element.
module obd_exec (
   // Clock and reset.
   input wire logic MCLK,
   input wire logic SYS_RST,
   // Instruction input.
   input wire logic START,
   input wire logic [15:0] INSTR_WORD0,
   input wire logic [15:0] INSTR_WORD1,
   input wire logic [31:0] INSTR_PC,
   input wire logic SEGMENTED,
   input wire logic SYSTEM_MODE,
   input wire logic LONG_SEG_ADDR,
   // Operands supplied by the register file and memory stage.
   input wire logic [15:0] DST_VALUE,
   input wire logic [15:0] SRC_VALUE,
   input wire logic [31:0] SRC_PTR,
   input wire logic [15:0] PORT_ADDR,
   input wire logic [15:0] COUNT_VALUE,
   // Memory read for block output.
   output logic [31:0] MEM_ADDR,
   output logic MEM_RD,
   input wire logic MEM_ACK,
   input wire logic [15:0] MEM_DATA,
   // I/O output stream.
   output logic IO_VALID,
   input wire logic IO_READY,
   output obd_pkg::obd_io_type IO_OUT,
   // Interrupt request.
   input wire logic INT_REQ,
   output logic INT_ACCEPT,
   output logic [31:0] SAVED_PC,
   // Results.
   output logic BUSY,
   output logic DONE,
   output logic TRAP_PRIV,
   output logic ILLEGAL,
   output logic [15:0] RESULT,
   output obd_pkg::obd_flag_type FLAGS,
   output logic [31:0] PTR_OUT,
   output logic [15:0] COUNT_OUT,
   output logic [15:0] PORT_OUT,
   output logic OVERFLOW_SET,
   output logic [4:0] CYCLES
);
   typedef enum {IDLE, OR_WAIT, BLK_SETUP, BLK_READ, BLK_PUSH, BLK_WAIT, BLK_INT} obd_state_type;

   obd_state_type state, next_state;
   logic [4:0] timer, next_timer;
   logic [15:0] result, next_result;
   obd_pkg::obd_flag_type flags, next_flags;
   logic [31:0] ptr, next_ptr;
   logic [15:0] count, next_count;
   logic [15:0] port, next_port;
   logic word, next_word;
   logic special, next_special;
   logic [15:0] data, next_data;
   logic [31:0] saved_pc, next_saved_pc;
   logic [31:0] start_pc, next_start_pc;
   logic done, next_done;
   logic trap, next_trap;
   logic illegal, next_illegal;
   logic int_acc, next_int_acc;
   logic vflag, next_vflag;
   logic [4:0] cycles, next_cycles;
   logic last, next_last;
   logic buf_valid;
   logic buf_ready;

   // Decode fields of the first word, and of the second word for block output.
   logic sz;
   logic [3:0] src_reg_field;
   logic is_or_reg, is_or_imm, is_or_ind, is_or_mem, is_blk;
   assign sz = INSTR_WORD0[obd_pkg::SIZE_BIT];
   assign src_reg_field = INSTR_WORD0[7:4];
   assign is_or_reg = INSTR_WORD0[15:9] == obd_pkg::OR_REG_OP;
   assign is_or_imm = INSTR_WORD0[15:8] == obd_pkg::OR_IMM_WORD_OP ||
                      INSTR_WORD0[15:8] == obd_pkg::OR_IMM_BYTE_OP;
   assign is_or_ind = INSTR_WORD0[15:9] == obd_pkg::OR_IND_OP && src_reg_field != 4'h0;
   assign is_or_mem = INSTR_WORD0[15:9] == obd_pkg::OR_MEM_OP;
   assign is_blk = INSTR_WORD0[15:9] == obd_pkg::BLK_OUT_OP &&
                   INSTR_WORD0[3:1] == obd_pkg::BLK_OUT_DEC_SUB && src_reg_field != 4'h0 &&
                   INSTR_WORD1[7:4] != 4'h0;

   // Decode, OR datapath and block output sequencing.
   always_comb begin
      logic [15:0] orv;
      logic [4:0] cyc;
      orv = DST_VALUE | SRC_VALUE;
      cyc = obd_pkg::CYC_OR_REG;
      next_state = state;
      next_timer = timer;
      next_result = result;
      next_flags = flags;
      next_ptr = ptr;
      next_count = count;
      next_port = port;
      next_word = word;
      next_special = special;
      next_data = data;
      next_saved_pc = saved_pc;
      next_start_pc = start_pc;
      next_done = 1'b0;
      next_trap = 1'b0;
      next_illegal = 1'b0;
      next_int_acc = 1'b0;
      next_vflag = vflag;
      next_cycles = cycles;
      next_last = last;
      buf_valid = 1'b0;
      case (state)
         IDLE: begin
            if (START) begin
               if (is_or_reg || is_or_imm || is_or_ind || is_or_mem) begin
                  if (!sz) begin
                     orv = {8'h00, orv[7:0]};
                  end
                  next_result = orv;
                  next_flags.zero = orv == obd_pkg::RESET_WORD;
                  next_flags.sign = sz ? orv[15] : orv[7];
                  next_flags.parity = sz ? flags.parity : ~^orv[7:0];
                  if (is_or_imm) begin
                     cyc = obd_pkg::CYC_OR_IMM;
                  end else if (is_or_ind) begin
                     cyc = obd_pkg::CYC_OR_IND;
                  end else if (is_or_mem && src_reg_field == 4'h0) begin
                     cyc = !SEGMENTED ? obd_pkg::CYC_OR_DA_NS :
                           (LONG_SEG_ADDR ? obd_pkg::CYC_OR_DA_SL : obd_pkg::CYC_OR_DA_SS);
                  end else if (is_or_mem) begin
                     cyc = !SEGMENTED ? obd_pkg::CYC_OR_X_NS :
                           (LONG_SEG_ADDR ? obd_pkg::CYC_OR_X_SL : obd_pkg::CYC_OR_X_SS);
                  end
                  next_cycles = cyc;
                  next_timer = cyc - 5'h01;
                  next_state = OR_WAIT;
               end else if (is_blk) begin
                  if (!SYSTEM_MODE) begin
                     next_trap = 1'b1;
                     next_done = 1'b1;
                  end else begin
                     next_word = sz;
                     next_special = INSTR_WORD0[obd_pkg::SPECIAL_BIT];
                     next_ptr = SEGMENTED ? SRC_PTR : {16'h0000, SRC_PTR[15:0]};
                     next_port = PORT_ADDR;
                     next_count = COUNT_VALUE;
                     next_start_pc = INSTR_PC;
                     next_vflag = 1'b0;
                     next_cycles = obd_pkg::CYC_BLK_SETUP;
                     next_timer = obd_pkg::CYC_BLK_SETUP - 5'h01;
                     next_state = BLK_SETUP;
                  end
               end else begin
                  next_illegal = 1'b1;
                  next_done = 1'b1;
               end
            end
         end
         OR_WAIT: begin
            if (timer == 5'h01) begin
               next_done = 1'b1;
               next_state = IDLE;
            end else begin
               next_timer = timer - 5'h01;
            end
         end
         BLK_SETUP: begin
            if (timer == 5'h01) begin
               next_state = BLK_READ;
            end else begin
               next_timer = timer - 5'h01;
            end
         end
         BLK_READ: begin
            if (MEM_ACK) begin
               next_data = word ? MEM_DATA : {8'h00, MEM_DATA[7:0]};
               next_state = BLK_PUSH;
            end
         end
         BLK_PUSH: begin
            buf_valid = 1'b1;
            if (buf_ready) begin
               next_ptr = SEGMENTED ? {ptr[31:16], ptr[15:0] - (word ? 16'h0002 : 16'h0001)} :
                          ptr - (word ? 32'h0000_0002 : 32'h0000_0001);
               next_count = count - 16'h0001;
               next_last = (count - 16'h0001) == 16'h0000;
               next_timer = obd_pkg::CYC_BLK_ELEM - 5'h03;
               next_state = BLK_WAIT;
            end
         end
         BLK_WAIT: begin
            if (timer != 5'h01) begin
               next_timer = timer - 5'h01;
            end else if (last) begin
               next_vflag = 1'b1;
               next_done = 1'b1;
               next_state = IDLE;
            end else if (INT_REQ) begin
               next_saved_pc = start_pc;
               next_int_acc = 1'b1;
               next_timer = obd_pkg::CYC_INT_EXTRA;
               next_state = BLK_INT;
            end else begin
               next_state = BLK_READ;
            end
         end
         BLK_INT: begin
            if (timer == 5'h01) begin
               next_done = 1'b1;
               next_state = IDLE;
            end else begin
               next_timer = timer - 5'h01;
            end
         end
         default: begin
            next_state = IDLE;
         end
      endcase
   end

   // Registers the executor state.
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         state <= IDLE;
         timer <= 5'h00;
         result <= obd_pkg::RESET_WORD;
         flags <= '0;
         ptr <= 32'h0000_0000;
         count <= obd_pkg::RESET_WORD;
         port <= obd_pkg::RESET_WORD;
         word <= 1'b0;
         special <= 1'b0;
         data <= obd_pkg::RESET_WORD;
         saved_pc <= 32'h0000_0000;
         start_pc <= 32'h0000_0000;
         done <= 1'b0;
         trap <= 1'b0;
         illegal <= 1'b0;
         int_acc <= 1'b0;
         vflag <= 1'b0;
         cycles <= 5'h00;
         last <= 1'b0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         result <= next_result;
         flags <= next_flags;
         ptr <= next_ptr;
         count <= next_count;
         port <= next_port;
         word <= next_word;
         special <= next_special;
         data <= next_data;
         saved_pc <= next_saved_pc;
         start_pc <= next_start_pc;
         done <= next_done;
         trap <= next_trap;
         illegal <= next_illegal;
         int_acc <= next_int_acc;
         vflag <= next_vflag;
         cycles <= next_cycles;
         last <= next_last;
      end
   end

   // Output buffer toward the I/O side.
   obd_buf #(.WIDTH($bits(obd_pkg::obd_io_type))) u_buf (
      .clk(MCLK),
      .rst(SYS_RST),
      .in_valid(buf_valid),
      .in_ready(buf_ready),
      .in_data({port, data, word, special}),
      .out_valid(IO_VALID),
      .out_ready(IO_READY),
      .out_data(IO_OUT)
   );

   // Output drives.
   assign MEM_ADDR = ptr;
   assign MEM_RD = state == BLK_READ;
   assign INT_ACCEPT = int_acc;
   assign SAVED_PC = saved_pc;
   assign BUSY = state != IDLE;
   assign DONE = done;
   assign TRAP_PRIV = trap;
   assign ILLEGAL = illegal;
   assign RESULT = result;
   assign FLAGS = flags;
   assign PTR_OUT = ptr;
   assign COUNT_OUT = count;
   assign PORT_OUT = port;
   assign OVERFLOW_SET = vflag;
   assign CYCLES = cycles;
endmodule // obd_exec

// ===== test/obd_exec_checker.sv
// Checker of timing and port relations for the OR and block output executor.
module obd_exec_checker (
   // Clock, reset and request.
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic START,
   input wire logic BUSY,
   input wire logic SYSTEM_MODE,
   input wire logic [15:0] INSTR_WORD0,
   input wire logic [15:0] INSTR_WORD1,
   input wire logic [31:0] INSTR_PC,
   input wire logic [15:0] DST_VALUE,
   input wire logic [15:0] SRC_VALUE,
   input wire logic [15:0] PORT_ADDR,
   // Results and stream.
   input wire logic DONE,
   input wire logic TRAP_PRIV,
   input wire logic MEM_RD,
   input wire logic IO_VALID,
   input wire obd_pkg::obd_io_type IO_OUT,
   input wire logic INT_ACCEPT,
   input wire logic [31:0] SAVED_PC,
   input wire logic OVERFLOW_SET,
   input wire logic [15:0] RESULT,
   input wire obd_pkg::obd_flag_type FLAGS,
   input wire logic [15:0] COUNT_OUT,
   input wire logic [4:0] CYCLES
);
   logic take, reg_or, blk, word_or, spec_cap;
   logic [15:0] exp_or, port_cap;
   logic [31:0] pc_cap;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   // Decodes the request taken at this edge.
   assign take = START && !BUSY;
   assign reg_or = INSTR_WORD0[15:9] == obd_pkg::OR_REG_OP;
   assign blk = INSTR_WORD0[15:9] == obd_pkg::BLK_OUT_OP && INSTR_WORD0[3:1] == obd_pkg::BLK_OUT_DEC_SUB;
   // Holds what the instruction in flight must produce, so later outputs can be compared.
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         word_or <= 1'b0;
      end else if (take) begin
         exp_or <= DST_VALUE | SRC_VALUE;
         word_or <= reg_or && INSTR_WORD0[8];
         port_cap <= PORT_ADDR;
         spec_cap <= INSTR_WORD0[0];
         pc_cap <= INSTR_PC;
      end
   end
   property p_or_time; take && reg_or |-> ##4 (DONE && CYCLES == obd_pkg::CYC_OR_REG); endproperty
   a_or_time: assert property (p_or_time) else $error("register OR timing wrong");
   property p_or_result; DONE && word_or |-> RESULT == exp_or; endproperty
   a_or_result: assert property (p_or_result) else $error("OR result wrong");
   property p_or_flags; DONE && word_or |-> FLAGS.zero == (RESULT == 16'h0000) && FLAGS.sign == RESULT[15]; endproperty
   a_or_flags: assert property (p_or_flags) else $error("OR flags wrong");
   property p_trap; take && blk && INSTR_WORD0[7:4] != 4'h0 && INSTR_WORD1[7:4] != 4'h0 && !SYSTEM_MODE
      |=> TRAP_PRIV && DONE; endproperty
   a_trap: assert property (p_trap) else $error("no privilege trap");
   property p_trap_quiet; TRAP_PRIV |-> !MEM_RD && !IO_VALID; endproperty
   a_trap_quiet: assert property (p_trap_quiet) else $error("transfer during trap");
   property p_port; IO_VALID |-> IO_OUT.port == port_cap; endproperty
   a_port: assert property (p_port) else $error("port address wrong");
   property p_special; IO_VALID |-> IO_OUT.special == spec_cap; endproperty
   a_special: assert property (p_special) else $error("I/O cycle kind wrong");
   property p_saved_pc; INT_ACCEPT |-> SAVED_PC == pc_cap ##1 !INT_ACCEPT; endproperty
   a_saved_pc: assert property (p_saved_pc) else $error("saved address wrong");
   property p_end_count; DONE && OVERFLOW_SET |-> COUNT_OUT == 16'h0000; endproperty
   a_end_count: assert property (p_end_count) else $error("ended with count left");
endmodule // obd_exec_checker

bind obd_exec obd_exec_checker u_obd_exec_checker (.MCLK(MCLK), .SYS_RST(SYS_RST), .START(START), .BUSY(BUSY),
   .SYSTEM_MODE(SYSTEM_MODE), .INSTR_WORD0(INSTR_WORD0), .INSTR_WORD1(INSTR_WORD1), .INSTR_PC(INSTR_PC),
   .DST_VALUE(DST_VALUE),
   .SRC_VALUE(SRC_VALUE), .PORT_ADDR(PORT_ADDR), .DONE(DONE), .TRAP_PRIV(TRAP_PRIV), .MEM_RD(MEM_RD),
   .IO_VALID(IO_VALID), .IO_OUT(IO_OUT), .INT_ACCEPT(INT_ACCEPT), .SAVED_PC(SAVED_PC), .OVERFLOW_SET(OVERFLOW_SET),
   .RESULT(RESULT), .FLAGS(FLAGS), .COUNT_OUT(COUNT_OUT), .CYCLES(CYCLES));

// ===== test/obd_mem_io_model.sv
// Memory and output port model on the far side of the executor.
module obd_mem_io_model (
   // Clock and pace.
   input wire logic clk,
   input wire logic slow,
   // Memory read.
   input wire logic mem_rd,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [15:0] mem_data,
   // Output port.
   output logic io_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_cnt;
   initial begin
      mem_ack = 1'b0;
      mem_data = 16'h0000;
      io_ready = 1'b1;
      wait_cnt = 2'h3;
   end
   // Answers reads after a wait when slow; data is scrambled while not acknowledged.
   always @(posedge clk) begin
      if (mem_rd && !mem_ack && (wait_cnt == 2'h0 || !slow)) begin
         mem_ack <= 1'b1;
         mem_data <= mem_addr[15:0] ^ 16'h5a3c;
         wait_cnt <= 2'h3;
      end else begin
         mem_ack <= 1'b0;
         mem_data <= ~mem_data;
         wait_cnt <= (mem_rd && wait_cnt != 2'h0) ? wait_cnt - 2'h1 : wait_cnt;
      end
      io_ready <= !slow || !io_ready;
   end
endmodule // obd_mem_io_model

// ===== test/obd_exec_test.sv
// Self-checking bench for the OR and block output executor.
module obd_exec_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK, SYS_RST, START, SEGMENTED, SYSTEM_MODE, LONG_SEG_ADDR, INT_REQ, slow, w;
   logic [15:0] INSTR_WORD0, INSTR_WORD1, DST_VALUE, SRC_VALUE, PORT_ADDR, COUNT_VALUE, MEM_DATA, RESULT;
   logic [15:0] COUNT_OUT, PORT_OUT;
   logic [31:0] INSTR_PC, SRC_PTR, MEM_ADDR, SAVED_PC, PTR_OUT, seed;
   logic MEM_RD, MEM_ACK, IO_VALID, IO_READY, INT_ACCEPT, BUSY, DONE, TRAP_PRIV, ILLEGAL, OVERFLOW_SET;
   logic trap_seen, ill_seen, int_seen;
   logic [4:0] CYCLES;
   obd_pkg::obd_io_type IO_OUT;
   obd_pkg::obd_flag_type FLAGS;
   obd_pkg::obd_io_type q[$];
   int mismatches, checks, k, k2, n;
   obd_exec u_obd_exec (.MCLK(MCLK), .SYS_RST(SYS_RST), .START(START), .INSTR_WORD0(INSTR_WORD0),
      .INSTR_WORD1(INSTR_WORD1), .INSTR_PC(INSTR_PC), .SEGMENTED(SEGMENTED), .SYSTEM_MODE(SYSTEM_MODE),
      .LONG_SEG_ADDR(LONG_SEG_ADDR), .DST_VALUE(DST_VALUE), .SRC_VALUE(SRC_VALUE), .SRC_PTR(SRC_PTR),
      .PORT_ADDR(PORT_ADDR), .COUNT_VALUE(COUNT_VALUE), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_ACK(MEM_ACK),
      .MEM_DATA(MEM_DATA), .IO_VALID(IO_VALID), .IO_READY(IO_READY), .IO_OUT(IO_OUT), .INT_REQ(INT_REQ),
      .INT_ACCEPT(INT_ACCEPT), .SAVED_PC(SAVED_PC), .BUSY(BUSY), .DONE(DONE), .TRAP_PRIV(TRAP_PRIV),
      .ILLEGAL(ILLEGAL), .RESULT(RESULT), .FLAGS(FLAGS), .PTR_OUT(PTR_OUT), .COUNT_OUT(COUNT_OUT),
      .PORT_OUT(PORT_OUT), .OVERFLOW_SET(OVERFLOW_SET), .CYCLES(CYCLES));
   obd_mem_io_model u_obd_mem_io_model (.clk(MCLK), .slow(slow), .mem_rd(MEM_RD), .mem_addr(MEM_ADDR),
      .mem_ack(MEM_ACK), .mem_data(MEM_DATA), .io_ready(IO_READY));
   // Clock of 20 ns period.
   initial begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end
   // Fixed-seed xorshift source of operands.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Presents one instruction for a single cycle.
   task automatic take(input logic [15:0] w0, input logic [15:0] w1);
      @(posedge MCLK);
      START <= 1'b1;
      INSTR_WORD0 <= w0;
      INSTR_WORD1 <= w1;
      @(posedge MCLK);
      START <= 1'b0;
   endtask
   // Waits for completion counting cycles, collects output words, then drains the buffer.
   task automatic run();
      // The edge that samples START counts as the first cycle of the instruction.
      n = 1;
      q.delete();
      int_seen = 1'b0;
      repeat (3000) begin
         @(negedge MCLK);
         if (IO_VALID && IO_READY) q.push_back(IO_OUT);
         if (INT_ACCEPT) int_seen = 1'b1;
         if (DONE) break;
         @(posedge MCLK);
         n++;
      end
      trap_seen = TRAP_PRIV;
      ill_seen = ILLEGAL;
      chk(DONE, 1);
      repeat (100) begin
         if (!IO_VALID) break;
         @(negedge MCLK);
         if (IO_VALID && IO_READY) q.push_back(IO_OUT);
      end
      $display("test done at %0t", $time);
   endtask
   // One OR with random operands against the integer model.
   task automatic do_or(input logic [15:0] w0, input logic seg, input logic lng, input int cyc, input logic byt);
      logic [15:0] d, s, r;
      d = 16'(xs());
      s = 16'(xs());
      r = d | s;
      @(posedge MCLK);
      DST_VALUE <= d;
      SRC_VALUE <= s;
      SEGMENTED <= seg;
      LONG_SEG_ADDR <= lng;
      take(w0, 16'(xs()));
      run();
      chk(n, cyc);
      chk(CYCLES, cyc);
      if (byt) chk({RESULT[7:0], FLAGS}, {r[7:0], r[7:0] == 8'h00, r[7], ~^r[7:0]});
      else chk({RESULT, FLAGS.zero, FLAGS.sign}, {r, r == 16'h0000, r[15]});
   endtask
   // One block output, checked element by element against the integer model.
   task automatic do_blk(input logic wd, input logic sp, input logic sys, input logic irq, input logic [15:0] cnt,
      input logic [31:0] ptr, output int got);
      logic [31:0] p, pc;
      logic [15:0] port, mask;
      port = 16'(xs());
      pc = xs();
      p = ptr;
      mask = wd ? 16'hffff : 16'h00ff;
      @(posedge MCLK);
      SRC_PTR <= ptr;
      PORT_ADDR <= port;
      COUNT_VALUE <= cnt;
      SYSTEM_MODE <= sys;
      INT_REQ <= irq;
      INSTR_PC <= pc;
      SEGMENTED <= 1'b0;
      take({7'h1d, wd, 4'hc, 3'h5, sp}, 16'h0790);
      run();
      got = q.size();
      if (!sys) begin
         chk({trap_seen, 31'(got)}, {1'b1, 31'h0});
      end else begin
         foreach (q[j]) begin
            chk(q[j].port, port);
            chk(q[j].data & mask, (p[15:0] ^ 16'h5a3c) & mask);
            chk({q[j].word, q[j].special}, {wd, sp});
            p = p - (wd ? 32'h2 : 32'h1);
         end
         chk(PTR_OUT, p);
         chk({COUNT_OUT, PORT_OUT}, {cnt - 16'(got), port});
         if (!slow) chk(n, 11 + 10 * got + (irq ? 7 : 0));
         if (irq) begin
            chk({int_seen, OVERFLOW_SET}, 2'h2);
            chk(SAVED_PC, pc);
         end else begin
            chk({OVERFLOW_SET, 31'(got)}, {1'b1, 31'(cnt)});
         end
      end
   endtask
   // Watchdog sized well above the expected run length.
   initial begin
      repeat (20000) @(posedge MCLK);
      mismatches++;
      results();
   end
   // Main sequence.
   initial begin
      {START, SEGMENTED, LONG_SEG_ADDR, INT_REQ, slow} = 5'h00;
      SYSTEM_MODE = 1'b1;
      {INSTR_WORD0, INSTR_WORD1, DST_VALUE, SRC_VALUE, PORT_ADDR, COUNT_VALUE} = 96'h0;
      {INSTR_PC, SRC_PTR} = 64'h0;
      seed = 32'd47821;
      mismatches = 0;
      checks = 0;
      SYS_RST = 1'b1;
      repeat (8) @(posedge MCLK);
      SYS_RST <= 1'b0;
      @(negedge MCLK);
      chk({BUSY, DONE, IO_VALID}, 3'h0);
      for (int i = 0; i < 2; i++) begin
         w = i[0];
         do_or({7'h42, w, 4'h3, 4'h1}, 1'b0, 1'b0, 4, !w);
         do_or({7'h02, w, 4'h5, 4'h2}, 1'b1, 1'b0, 7, !w);
         do_or({7'h22, w, 4'h0, 4'h3}, 1'b0, 1'b0, 9, !w);
         do_or({7'h22, w, 4'h0, 4'h3}, 1'b1, 1'b0, 10, !w);
         do_or({7'h22, w, 4'h0, 4'h3}, 1'b1, 1'b1, 12, !w);
         do_or({7'h22, w, 4'h6, 4'h4}, 1'b0, 1'b0, 10, !w);
         do_or({7'h22, w, 4'h6, 4'h4}, 1'b1, 1'b0, 10, !w);
         do_or({7'h22, w, 4'h6, 4'h4}, 1'b1, 1'b1, 13, !w);
      end
      do_or(16'h0507, 1'b0, 1'b0, 7, 1'b0);
      do_or(16'h0408, 1'b1, 1'b0, 7, 1'b1);
      take({7'h1d, 1'b1, 4'h0, 3'h5, 1'b0}, 16'h0790);
      run();
      chk({ill_seen, 31'(q.size())}, {1'b1, 31'h0});
      do_blk(1'b1, 1'b0, 1'b0, 1'b0, 16'd3, 32'h0000b006, k);
      do_blk(1'b1, 1'b0, 1'b1, 1'b0, 16'd3, 32'h0000b006, k);
      slow <= 1'b1;
      do_blk(1'b0, 1'b1, 1'b1, 1'b0, 16'd4, 32'h00001235, k);
      slow <= 1'b0;
      do_blk(1'b1, 1'b1, 1'b1, 1'b1, 16'd5, 32'h00004000, k);
      do_blk(1'b1, 1'b1, 1'b1, 1'b0, 16'(5 - k), 32'h00004000 - 32'(2 * k), k2);
      chk(k + k2, 5);
      results();
   end
endmodule // obd_exec_test
